// ### hdl/motor_fault_pkg.sv
package motor_fault_pkg;

  // register index width; byte address is four times the index
  localparam int          REG_IDX_W          = 3;
  localparam logic [2:0]  IDX_FAULT_FLAGS    = 3'h0;
  localparam logic [2:0]  IDX_ROTOR_SPEED    = 3'h1;
  localparam logic [2:0]  IDX_ROTOR_PERIOD   = 3'h2;
  localparam logic [2:0]  IDX_VELOCITY_CONST = 3'h3;
  localparam logic [2:0]  IDX_PEAK_CURRENT   = 3'h4;
  localparam logic [2:0]  IDX_MEAS_CTRL      = 3'h5;
  localparam logic [2:0]  IDX_FAULT_LIVE     = 3'h6;
  localparam logic [2:0]  IDX_LAST           = 3'h6;

  // fault flag bit positions
  localparam int THERMAL_SHUTDOWN_BIT  = 15;
  localparam int THERMAL_WARN_BIT      = 14;
  localparam int SUPPLY_OVER_VOLT_BIT  = 13;
  localparam int BUCK_OVER_CURRENT_BIT = 12;
  localparam int PHASE_OVER_CURR_BIT   = 11;
  localparam int CHARGE_PUMP_LOW_BIT   = 10;
  localparam int BUCK_LOW_BIT          = 9;
  localparam int SUPPLY_LOW_BIT        = 8;
  localparam int LDO_LOW_BIT           = 7;
  localparam int FAULT_RESERVED_BIT    = 6;
  localparam int CLOSED_LOOP_STALL_BIT = 5;
  localparam int OPEN_LOOP_STALL_BIT   = 4;
  localparam int NO_MOTOR_BIT          = 3;
  localparam int BAD_VEL_CONST_BIT     = 2;
  localparam int BAD_SPEED_BIT         = 1;
  localparam int HW_CURRENT_LIMIT_BIT  = 0;

  // implemented flags; the reserved bit never sets
  localparam logic [15:0] FAULT_IMPL_MASK    = 16'hFFBF;
  localparam logic [15:0] FAULT_RESET        = 16'h0000;
  localparam logic [15:0] MEAS_RESET         = 16'h0000;
  localparam int          CUR_CODE_W         = 11;
  localparam int          MEAS_FREEZE_BIT    = 0;

  // fixed scalings seen by software
  localparam int SPEED_TENTHS_PER_HZ = 10;
  localparam int PERIOD_US_PER_LSB   = 10;
  localparam int VEL_CONST_DIV_A     = 2;
  localparam int VEL_CONST_DIV_B     = 1090;
  localparam int CUR_CODE_KNEE       = 1023;
  localparam int CUR_CODE_DIV        = 512;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// ### hdl/motor_fault_status_regs.sv
`timescale 1ns/1ps
// What this block does
// - bit 15 latches die over-temperature shutdown
// - bit 14 latches temperature warning independently
// - bit 13 latches supply over-voltage
// - bit 12 latches buck regulator overcurrent
// - bit 11 latches phase overcurrent events
// - bit 10 latches charge pump undervoltage
// - bits 9,8,7: buck, supply, LDO undervoltage
// - bit 6 reserved, always reads zero
// - bits 5..0 latch the six lock faults
// - speed register, 16 bits, tenths of hertz
// - period register, 16 bits, 10 us units
// - velocity constant register, 16 bits raw
// - peak current register holds 11-bit code
// - current register bits 15..11 read zero
module motor_fault_status_regs
  import motor_fault_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  // axi4-lite write address
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [ADDR_W-1:0]                     s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  // axi4-lite write response
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  output logic [1:0]                                 s_axi_bresp,
  // axi4-lite read address
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  input  wire logic [ADDR_W-1:0]                     s_axi_araddr,
  // axi4-lite read data
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  // fault conditions from protection monitors, asynchronous levels
  input  wire logic                                  thermal_shutdown_cond,
  input  wire logic                                  thermal_warn_cond,
  input  wire logic                                  supply_over_voltage_cond,
  input  wire logic                                  buck_over_current_cond,
  input  wire logic                                  phase_over_current_cond,
  input  wire logic                                  charge_pump_low_cond,
  input  wire logic                                  buck_low_cond,
  input  wire logic                                  supply_low_cond,
  input  wire logic                                  ldo_low_cond,
  input  wire logic                                  closed_loop_stall_cond,
  input  wire logic                                  open_loop_stall_cond,
  input  wire logic                                  no_motor_cond,
  input  wire logic                                  bad_velocity_const_cond,
  input  wire logic                                  bad_speed_cond,
  input  wire logic                                  hw_current_limit_cond,
  // measurements from the motor-control core, same clock
  input  wire logic [15:0]                           speed_value,
  input  wire logic                                  speed_load,
  input  wire logic [15:0]                           period_value,
  input  wire logic                                  period_load,
  input  wire logic [15:0]                           vel_const_value,
  input  wire logic                                  vel_const_load,
  input  wire logic [motor_fault_pkg::CUR_CODE_W-1:0] current_code,
  input  wire logic                                  current_load
);

  if (ADDR_W < REG_IDX_W + 3 || ADDR_W > 32)
  begin : g_addr_chk
    $error("ADDR_W must lie between 6 and 32");
  end

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = (a[ADDR_W-1:REG_IDX_W+2] == '0) && (a[REG_IDX_W+1:2] <= IDX_LAST);
  endfunction

  function automatic logic [REG_IDX_W-1:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[REG_IDX_W+1:2];
  endfunction

  // ---------------- fault condition synchronisers ----------------
  logic [15:0] fault_raw;
  logic [15:0] fault_sync1_ff;
  logic [15:0] fault_sync2_ff;

  assign fault_raw = {thermal_shutdown_cond,
                      thermal_warn_cond,
                      supply_over_voltage_cond,
                      buck_over_current_cond,
                      phase_over_current_cond,
                      charge_pump_low_cond,
                      buck_low_cond,
                      supply_low_cond,
                      ldo_low_cond,
                      1'b0,
                      closed_loop_stall_cond,
                      open_loop_stall_cond,
                      no_motor_cond,
                      bad_velocity_const_cond,
                      bad_speed_cond,
                      hw_current_limit_cond};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_sync1_ff <= FAULT_RESET;
      fault_sync2_ff <= FAULT_RESET;
    end
    else
    begin
      fault_sync1_ff <= fault_raw;
      fault_sync2_ff <= fault_sync1_ff;
    end
  end

  // ---------------- axi4-lite write path ----------------
  logic              aw_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              w_held_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;

  wire aw_take = s_axi_awvalid & ~aw_held_ff;
  wire w_take  = s_axi_wvalid & ~w_held_ff;
  // one write at a time: the next is carried out only once the response is gone, though its address and data can be taken before
  wire wr_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire wr_map  = addr_mapped(awaddr_ff);

  wire [REG_IDX_W-1:0] wr_idx       = addr_idx(awaddr_ff);
  wire                 wr_fault     = wr_fire & wr_map & (wr_idx == IDX_FAULT_FLAGS);
  wire                 wr_meas_ctrl = wr_fire & wr_map & (wr_idx == IDX_MEAS_CTRL) & wstrb_ff[0];
  wire [15:0]          lane_mask    = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  assign s_axi_awready = ~aw_held_ff;
  assign s_axi_wready  = ~w_held_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end
    else if (aw_take)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_ff <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end
    else if (w_take)
    begin
      w_held_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_map ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_bready)
    begin
      bvalid_ff <= 1'b0;
    end
  end

  // ---------------- sticky fault flags ----------------
  logic [15:0] fault_flags_ff;
  logic [15:0] fault_set;
  logic [15:0] fault_clr;
  logic [15:0] nxt_fault_flags;

  // a present condition sets its flag every cycle, so a clear cannot remove it
  assign fault_set = fault_sync2_ff & FAULT_IMPL_MASK;
  assign fault_clr = wr_fault ? (wdata_ff[15:0] & lane_mask) : 16'h0000;
  // set beats clear so an event landing on the clear cycle survives
  assign nxt_fault_flags = ((fault_flags_ff & ~fault_clr) | fault_set) & FAULT_IMPL_MASK;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      fault_flags_ff <= FAULT_RESET;
    else
      fault_flags_ff <= nxt_fault_flags;
  end

  // ---------------- measurement control ----------------
  // freeze lets software read all four measurements from one instant
  logic meas_freeze_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      meas_freeze_ff <= 1'b0;
    else if (wr_meas_ctrl)
      meas_freeze_ff <= wdata_ff[MEAS_FREEZE_BIT];
  end

  // ---------------- measurement registers ----------------
  logic [15:0]            rotor_speed_ff;
  logic [15:0]            rotor_period_ff;
  logic [15:0]            velocity_constant_ff;
  logic [CUR_CODE_W-1:0]  peak_current_ff;

  wire ld_speed  = speed_load & ~meas_freeze_ff;
  wire ld_period = period_load & ~meas_freeze_ff;
  wire ld_vconst = vel_const_load & ~meas_freeze_ff;
  wire ld_curr   = current_load & ~meas_freeze_ff;

  // each word loads whole in one edge, so a read never mixes two samples
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rotor_speed_ff       <= MEAS_RESET;
      rotor_period_ff      <= MEAS_RESET;
      velocity_constant_ff <= MEAS_RESET;
      peak_current_ff      <= '0;
    end
    else
    begin
      if (ld_speed)
        rotor_speed_ff <= speed_value;
      if (ld_period)
        rotor_period_ff <= period_value;
      if (ld_vconst)
        velocity_constant_ff <= vel_const_value;
      if (ld_curr)
        peak_current_ff <= current_code;
    end
  end

  // ---------------- axi4-lite read path ----------------
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;

  wire                 rd_take = s_axi_arvalid & ~rvalid_ff;
  wire                 rd_map  = addr_mapped(s_axi_araddr);
  wire [REG_IDX_W-1:0] rd_idx  = addr_idx(s_axi_araddr);
  wire [15:0]          cur_word = {{(16-CUR_CODE_W){1'b0}}, peak_current_ff};
  wire [15:0]          rd_word =
    !rd_map                        ? 16'h0000 :
    (rd_idx == IDX_FAULT_FLAGS)    ? fault_flags_ff :
    (rd_idx == IDX_ROTOR_SPEED)    ? rotor_speed_ff :
    (rd_idx == IDX_ROTOR_PERIOD)   ? rotor_period_ff :
    (rd_idx == IDX_VELOCITY_CONST) ? velocity_constant_ff :
    (rd_idx == IDX_PEAK_CURRENT)   ? cur_word :
    (rd_idx == IDX_MEAS_CTRL)      ? {15'h0000, meas_freeze_ff} :
                                     fault_set;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= {16'h0000, rd_word};
      rresp_ff  <= rd_map ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rready)
    begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule

// ### dv/motor_fault_status_regs_asserts.sv
`timescale 1ns/1ps
module motor_fault_status_regs_asserts #(
  parameter int ADDR_W = 8
)(
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // bus
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  // monitor
  input wire logic              thermal_shutdown_cond
);
  logic [ADDR_W-1:0] rd_addr_ff;
  wire  [ADDR_W-1:0] nxt_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr_ff;
  wire  [ADDR_W-3:0] rd_idx = rd_addr_ff[ADDR_W-1:2];
  always_ff @(posedge aclk) rd_addr_ff <= aresetn ? nxt_rd_addr : '0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper half set");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write late");
  resv_zero_a: assert property (s_axi_rvalid && rd_idx == 0 |-> !s_axi_rdata[6]) else $error("bit 6 set");
  cur_top_a: assert property (s_axi_rvalid && rd_idx == 4 |-> s_axi_rdata[15:11] == 5'h00) else $error("current top");
  unmapped_a: assert property (s_axi_rvalid && rd_idx > 6 |-> s_axi_rresp == 2'h3 && s_axi_rdata == 0) else $error("decode");
  temp_set_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == 0
    && $past(thermal_shutdown_cond, 3) && $past(aresetn, 3) && $past(aresetn, 2) && $past(aresetn)
    |=> s_axi_rdata[15]) else $error("shutdown flag missing");
endmodule
bind motor_fault_status_regs motor_fault_status_regs_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import motor_fault_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [15:0] cond = 16'h0000;
  logic [15:0] mv [4] = '{default: 16'h0000};
  logic [3:0] ld = 4'h0;
  logic [3:0] ws = 4'hf;
  int lag = 0;
  int meas_m [4] = '{default: 0};
  wire awr, wr_rdy, bv, arr, rv;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  int num_errors = 0, total_checks = 0, flags_m;
  motor_fault_status_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rrd), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .thermal_shutdown_cond(cond[15]), .thermal_warn_cond(cond[14]), .supply_over_voltage_cond(cond[13]),
    .buck_over_current_cond(cond[12]), .phase_over_current_cond(cond[11]), .charge_pump_low_cond(cond[10]),
    .buck_low_cond(cond[9]), .supply_low_cond(cond[8]), .ldo_low_cond(cond[7]), .closed_loop_stall_cond(cond[5]),
    .open_loop_stall_cond(cond[4]), .no_motor_cond(cond[3]), .bad_velocity_const_cond(cond[2]),
    .bad_speed_cond(cond[1]), .hw_current_limit_cond(cond[0]), .speed_value(mv[0]), .speed_load(ld[0]),
    .period_value(mv[1]), .period_load(ld[1]), .vel_const_value(mv[2]), .vel_const_load(ld[2]),
    .current_code(mv[3][10:0]), .current_load(ld[3]));
  initial forever #20 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw;
    @(posedge aclk);
    awa <= a; wd <= {16'h0000, d}; awv <= 1'b1; wv <= 1'b1; brd <= (lag == 0);
    pa = 1'b1; pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge aclk);
      ta = pa && awr; tw = pw && wr_rdy;
      @(posedge aclk);
      if (ta) begin awv <= 1'b0; pa = 1'b0; end
      if (tw) begin wv <= 1'b0; pw = 1'b0; end
    end
    do @(negedge aclk); while (bv !== 1'b1);
    // a late bready keeps the response waiting, so its hold is exercised
    if (lag != 0)
    begin
      repeat (lag) @(posedge aclk);
      brd <= 1'b1;
      @(negedge aclk);
    end
    chk("bresp", er, br);
    @(posedge aclk);
    brd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rrd <= (lag == 0);
    do @(negedge aclk); while (arr !== 1'b1);
    @(posedge aclk);
    arv <= 1'b0;
    do @(negedge aclk); while (rv !== 1'b1);
    if (lag != 0)
    begin
      repeat (lag) @(posedge aclk);
      rrd <= 1'b1;
      @(negedge aclk);
    end
    chk($sformatf("rdata@%h", a), e, rdat);
    chk("rresp", er, rr);
    @(posedge aclk);
    rrd <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #800000;
    num_errors++;
    final_report();
  end
  initial
  begin
    logic [15:0] v, c;
    logic [3:0]  s;
    void'($urandom(90));
    settle(12);
    aresetn <= 1'b1;
    settle(2);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000, RESP_OKAY);
    $display("test reset values done");
    for (int b = 15; b >= 0; b--)
    begin
      @(posedge aclk) cond <= 16'h0001 << b;
      flags_m = (b == FAULT_RESERVED_BIT) ? 0 : (1 << b);
      settle(4);
      rd(8'h00, flags_m, RESP_OKAY);
      rd(8'h18, flags_m, RESP_OKAY);
      wr(8'h00, 16'hffff, RESP_OKAY);
      rd(8'h00, flags_m, RESP_OKAY);
      @(posedge aclk) cond <= 16'h0000;
      settle(4);
      wr(8'h00, 16'hffff, RESP_OKAY);
      rd(8'h00, 32'h0000_0000, RESP_OKAY);
      rd(8'h18, 32'h0000_0000, RESP_OKAY);
    end
    $display("test single flags done");
    repeat (4)
    begin
      lag = int'($urandom % 4);
      c = 16'($urandom);
      @(posedge aclk) cond <= c;
      settle(4);
      @(posedge aclk) cond <= 16'h0000;
      settle(4);
      flags_m = c & FAULT_IMPL_MASK;
      rd(8'h00, flags_m, RESP_OKAY);
      v = 16'($urandom);
      s = 4'($urandom);
      @(posedge aclk) ws <= s;
      wr(8'h00, v, RESP_OKAY);
      // only byte lanes enabled by the strobe clear their flags
      flags_m = flags_m & ~(int'(v) & int'({{8{s[1]}}, {8{s[0]}}}));
      rd(8'h00, flags_m, RESP_OKAY);
      @(posedge aclk) ws <= 4'hf;
      wr(8'h00, 16'hffff, RESP_OKAY);
    end
    lag = 0;
    $display("test partial clear done");
    for (int k = 0; k < 4; k++)
      for (int n = 0; n < 3; n++)
      begin
        v = (n == 0) ? 16'hffff : 16'($urandom);
        if (k == 3 && n == 1) v = 16'(CUR_CODE_KNEE);
        @(posedge aclk);
        mv[k] <= v; ld <= 4'h1 << k;
        @(posedge aclk) ld <= 4'h0;
        if (k == 3) v = v & 16'h07ff;
        meas_m[k] = int'(v);
        rd(8'(4 * (k + 1)), v, RESP_OKAY);
        wr(8'(4 * (k + 1)), ~v, RESP_OKAY);
        rd(8'(4 * (k + 1)), v, RESP_OKAY);
      end
    $display("test measurements done");
    // a frozen bank ignores loads until software releases it
    wr(8'h14, 16'h0001, RESP_OKAY);
    rd(8'h14, 32'h0000_0001, RESP_OKAY);
    v = ~16'(meas_m[0]);
    @(posedge aclk);
    mv[0] <= v; ld <= 4'h1;
    @(posedge aclk) ld <= 4'h0;
    rd(8'h04, meas_m[0], RESP_OKAY);
    wr(8'h14, 16'h0000, RESP_OKAY);
    rd(8'h14, 32'h0000_0000, RESP_OKAY);
    @(posedge aclk) ld <= 4'h1;
    @(posedge aclk) ld <= 4'h0;
    meas_m[0] = int'(v);
    rd(8'h04, meas_m[0], RESP_OKAY);
    $display("test freeze done");
    rd(8'h1c, 32'h0000_0000, RESP_DECERR);
    wr(8'h1c, 16'hffff, RESP_DECERR);
    $display("test unmapped done");
    final_report();
  end
endmodule
